// ### include/sfsw_pkg.sv
// Contract
// - Busy flag high during program or erase
// - Busy flag at bit 0 of both bytes
// - Soft reset enable resets 0, gates reset
// - Soft reset enable kept; only byte-two write
// - Reserved byte-two bits read zero
// - Opcode 01h; lock bit 7, protect bit 2
// - Status writes need write enable latch set
// - Extra data bytes ignored in first write
// - Chip select rise applies lock, protect; clears latch
// - Protect change uses old lock, pin level
// - Partial byte aborts write, clears latch
// - Pin asserted: lock only goes 0 to 1
// - Opcode 31h; soft reset enable from bit 4
// - Byte-two write sole changer; clears latch
// - Extra data bytes ignored in byte-two write
// - Partial byte-two write aborts, clears latch
// - Opcode 05h reads byte one, two, repeating
// - Array protect refuses program and erase
// - Lock resets 0; with pin locks protect
package sfsw_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  // Status byte one fields
  localparam int S1_LOCK = 7;
  localparam int S1_PROG_ERR = 5;
  localparam int S1_PIN_STATE = 4;
  localparam int S1_PROTECT = 2;
  localparam int S1_LATCH = 1;
  localparam int S_BUSY = 0;
  // Status byte two fields
  localparam int S2_RST_EN = 4;
  // Write data fields
  localparam int WD_LOCK = 7;
  localparam int WD_PROTECT = 2;
  localparam int WD_RST_EN = 4;
  // Reset values
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_PROTECT = 1'b0;
  localparam logic RST_RST_EN = 1'b0;
  localparam logic RST_LATCH = 1'b0;
  // Host APB map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam int CMD_DATA0 = 8;
  localparam int CMD_DATA1 = 16;
  localparam int CMD_NBITS = 24;
  localparam int STAT_RX = 16;
  // Timing
  localparam int CLK_NS = 40;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_NS);
  // Device states
  typedef enum logic [5:0] {
    SFSW_IDLE = 6'h01,
    SFSW_OPC = 6'h02,
    SFSW_WR1 = 6'h04,
    SFSW_WR2 = 6'h08,
    SFSW_RD = 6'h10,
    SFSW_SKIP = 6'h20
  } sfsw_dev_state_t;
  // Host states
  typedef enum logic [2:0] {
    SFSW_H_IDLE = 3'h1,
    SFSW_H_RUN = 3'h2,
    SFSW_H_TAIL = 3'h4
  } sfsw_host_state_t;
endpackage

// ### include/sfsw_link_if.sv
`timescale 1ns/1ns
interface sfsw_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // Released line reads low
  assign miso_line = miso_oe ? miso : 1'b0;
  modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
  modport hst (output sck, output cs_n, output mosi, input miso_line);
endinterface

// ### core/sfsw_flash_dev.sv
`timescale 1ns/1ns
module sfsw_flash_dev (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  sfsw_link_if.dev link,
  // Core side
  input wire logic busy_flag,
  input wire logic program_error_flag,
  input wire logic wp_n,
  input wire logic reset_cmd_req,
  input wire logic prog_erase_req,
  output logic reset_cmd_accept,
  output logic prog_erase_refused,
  output logic soft_reset_enable,
  output logic protection_lock,
  output logic array_protect,
  output logic write_enable_latch
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [1:0] wp_s;
  logic sck_d1;
  logic cs_d1;

  // Two flops per pin, then delayed copies for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      wp_s <= 2'h3;
      sck_d1 <= 1'b0;
      cs_d1 <= 1'b1;
    end
    else
    begin
      sck_s <= {sck_s[0], link.sck};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      wp_s <= {wp_s[0], wp_n};
      sck_d1 <= sck_s[1];
      cs_d1 <= cs_s[1];
    end
  end

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic cs_end;
  logic wp_on;

  // Edge events
  assign sel = !cs_s[1];
  assign sck_rise = sel && sck_s[1] && !sck_d1;
  assign sck_fall = sel && !sck_s[1] && sck_d1;
  assign cs_end = cs_s[1] && !cs_d1;
  assign wp_on = !wp_s[1];

  ////////////////////////////////////////////////////////////////
  // Bit and byte counting
  logic [2:0] bit_idx_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] data_q;
  logic on_boundary;
  logic byte_done;

  assign byte_done = sck_rise && (bit_idx_q == 3'h7);
  assign on_boundary = (bit_idx_q == 3'h0);
  // Counters restart with each frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_idx_q <= 3'h0;
      byte_cnt_q <= 2'h0;
    end
    else if (cs_end)
    begin
      bit_idx_q <= 3'h0;
      byte_cnt_q <= 2'h0;
    end
    else if (sck_rise)
    begin
      bit_idx_q <= bit_idx_q + 3'h1;
      if (bit_idx_q == 3'h7 && byte_cnt_q != 2'h3)
        byte_cnt_q <= byte_cnt_q + 2'h1;
    end
  end

  // Input shifter, MSB first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift_q <= 8'h00;
    else if (sck_rise)
      shift_q <= {shift_q[6:0], mosi_s[1]};
  end

  // Keep only the first data byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_q <= 8'h00;
    else if (byte_done && byte_cnt_q == 2'h1)
      data_q <= {shift_q[6:0], mosi_s[1]};
  end

  ////////////////////////////////////////////////////////////////
  // Command decode
  sfsw_pkg::sfsw_dev_state_t state_q;
  logic [7:0] opc_in;
  logic wren_pending_q;
  assign opc_in = {shift_q[6:0], mosi_s[1]};

  // Frame state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= sfsw_pkg::SFSW_IDLE;
    else if (cs_end)
      state_q <= sfsw_pkg::SFSW_IDLE;
    else
    begin
      unique case (state_q)
        sfsw_pkg::SFSW_IDLE:
          if (sel)
            state_q <= sfsw_pkg::SFSW_OPC;
        sfsw_pkg::SFSW_OPC:
          if (byte_done)
          begin
            if (opc_in == sfsw_pkg::OP_READ_STATUS)
              state_q <= sfsw_pkg::SFSW_RD;
            else if (opc_in == sfsw_pkg::OP_WRITE_STATUS1 && write_enable_latch)
              state_q <= sfsw_pkg::SFSW_WR1;
            else if (opc_in == sfsw_pkg::OP_WRITE_STATUS2 && write_enable_latch)
              state_q <= sfsw_pkg::SFSW_WR2;
            else
              state_q <= sfsw_pkg::SFSW_SKIP;
          end
        sfsw_pkg::SFSW_WR1, sfsw_pkg::SFSW_WR2, sfsw_pkg::SFSW_RD, sfsw_pkg::SFSW_SKIP:
          state_q <= state_q;
        default:
          state_q <= sfsw_pkg::SFSW_IDLE;
      endcase
    end
  end

  // Write enable opcode with no later clock in this frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wren_pending_q <= 1'b0;
    else if (cs_end)
      wren_pending_q <= 1'b0;
    else if (state_q == sfsw_pkg::SFSW_OPC && byte_done)
      wren_pending_q <= (opc_in == sfsw_pkg::OP_WRITE_ENABLE);
    else if (sck_rise)
      wren_pending_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Status bits updated at chip select rise
  logic write_ok;
  logic new_lock;
  logic new_prot;
  logic lock_refused;

  // Full data byte and frame ends on a byte edge
  assign write_ok = on_boundary && byte_cnt_q >= 2'h2;
  assign new_lock = data_q[sfsw_pkg::WD_LOCK];
  assign new_prot = data_q[sfsw_pkg::WD_PROTECT];
  assign lock_refused = wp_on && protection_lock && !new_lock;
  // Lock and protect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      protection_lock <= sfsw_pkg::RST_LOCK;
      array_protect <= sfsw_pkg::RST_PROTECT;
    end
    else if (cs_end && state_q == sfsw_pkg::SFSW_WR1 && write_ok && !lock_refused)
    begin
      protection_lock <= new_lock;
      if (!(wp_on && protection_lock))
        array_protect <= new_prot;
    end
  end

  // Soft reset enable, changed only here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_reset_enable <= sfsw_pkg::RST_RST_EN;
    else if (cs_end && state_q == sfsw_pkg::SFSW_WR2 && write_ok)
      soft_reset_enable <= data_q[sfsw_pkg::WD_RST_EN];
  end

  // Write enable latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      write_enable_latch <= sfsw_pkg::RST_LATCH;
    else if (cs_end && (state_q == sfsw_pkg::SFSW_WR1 || state_q == sfsw_pkg::SFSW_WR2))
      write_enable_latch <= 1'b0;
    else if (cs_end && wren_pending_q && on_boundary)
      write_enable_latch <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // Status read out
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [15:0] out_q;
  logic [3:0] out_cnt_q;
  logic out_on_q;

  // Byte one and byte two images
  always_comb
  begin
    stat1 = 8'h00;
    stat1[sfsw_pkg::S1_LOCK] = protection_lock;
    stat1[sfsw_pkg::S1_PROG_ERR] = program_error_flag;
    stat1[sfsw_pkg::S1_PIN_STATE] = wp_s[1];
    stat1[sfsw_pkg::S1_PROTECT] = array_protect;
    stat1[sfsw_pkg::S1_LATCH] = write_enable_latch;
    stat1[sfsw_pkg::S_BUSY] = busy_flag;
    stat2 = 8'h00;
    stat2[sfsw_pkg::S2_RST_EN] = soft_reset_enable;
    stat2[sfsw_pkg::S_BUSY] = busy_flag;
  end

  // Shift on falling clock, reload every two bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= 16'h0000;
      out_cnt_q <= 4'h0;
      out_on_q <= 1'b0;
    end
    else if (cs_end)
    begin
      out_cnt_q <= 4'h0;
      out_on_q <= 1'b0;
    end
    else if (sck_fall && state_q == sfsw_pkg::SFSW_RD)
    begin
      out_on_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 4'h1;
      if (out_cnt_q == 4'h0)
        out_q <= {stat1, stat2};
      else
        out_q <= {out_q[14:0], 1'b0};
    end
  end

  assign link.miso = out_q[15];
  assign link.miso_oe = out_on_q && sel;

  ////////////////////////////////////////////////////////////////
  // Gates toward the core
  assign reset_cmd_accept = reset_cmd_req && soft_reset_enable;
  assign prog_erase_refused = prog_erase_req && array_protect;
endmodule

// ### core/sfsw_host_ctrl.sv
`timescale 1ns/1ns
module sfsw_host_ctrl #(
  parameter int HALF_CYC = sfsw_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  sfsw_link_if.hst link
);
  ////////////////////////////////////////////////////////////////
  // Register access
  logic acc;
  logic hit_cmd;
  logic hit_stat;
  logic [31:0] cmd_q;
  logic [15:0] rx_q;
  logic busy;
  logic start;

  assign acc = psel && penable;
  assign hit_cmd = (paddr == sfsw_pkg::OFS_CMD);
  assign hit_stat = (paddr == sfsw_pkg::OFS_STAT);
  assign pready = 1'b1;
  assign start = acc && pwrite && hit_cmd && !busy;

  // Command word, refused while busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_q <= 32'h00000000;
    else if (start)
      cmd_q <= {3'h0, pwdata[28:0]};
  end

  // Read data and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= !(hit_cmd || hit_stat);
      if (pwrite || !(hit_cmd || hit_stat))
        prdata <= 32'h00000000;
      else if (hit_cmd)
        prdata <= cmd_q;
      else
        prdata <= {rx_q, 15'h0000, busy};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Link sequencer
  sfsw_pkg::sfsw_host_state_t st_q;
  logic [7:0] div_q;
  logic tick;
  logic [23:0] tx_q;
  logic [5:0] bits_left_q;
  logic sck_q;

  assign busy = (st_q != sfsw_pkg::SFSW_H_IDLE);
  assign tick = busy && (div_q == 8'(HALF_CYC - 1));

  // Half period divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 8'h00;
    else if (!busy || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  // Frame sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= sfsw_pkg::SFSW_H_IDLE;
      sck_q <= 1'b0;
      tx_q <= 24'h000000;
      bits_left_q <= 6'h00;
      rx_q <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        sfsw_pkg::SFSW_H_IDLE:
          if (start)
          begin
            st_q <= sfsw_pkg::SFSW_H_RUN;
            tx_q <= {pwdata[7:0], pwdata[15:8], pwdata[23:16]};
            bits_left_q <= 6'h08 + {1'b0, pwdata[28:24]};
          end
        sfsw_pkg::SFSW_H_RUN:
          if (tick)
          begin
            sck_q <= !sck_q;
            if (!sck_q)
            begin
              rx_q <= {rx_q[14:0], link.miso_line};
              bits_left_q <= bits_left_q - 6'h01;
            end
            else if (bits_left_q == 6'h00)
            begin
              st_q <= sfsw_pkg::SFSW_H_TAIL;
            end
            else
              tx_q <= {tx_q[22:0], 1'b0};
          end
        sfsw_pkg::SFSW_H_TAIL:
          if (tick)
            st_q <= sfsw_pkg::SFSW_H_IDLE;
        default:
          st_q <= sfsw_pkg::SFSW_H_IDLE;
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = !(st_q == sfsw_pkg::SFSW_H_RUN);
  assign link.mosi = tx_q[23];
endmodule

// ### tb/sfsw_props.sv
`timescale 1ns/1ns
module sfsw_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso_oe,
  // Device side
  input wire logic wp_n,
  input wire logic reset_cmd_req,
  input wire logic reset_cmd_accept,
  input wire logic prog_erase_req,
  input wire logic prog_erase_refused,
  input wire logic soft_reset_enable,
  input wire logic protection_lock,
  input wire logic array_protect,
  input wire logic write_enable_latch
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // Link framing
  property p_idle_sck; cs_n |-> !sck; endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("sck high while deselected");
  property p_oe_off; cs_n [*5] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while deselected");
  property p_oe_on; $rose(miso_oe) |-> !cs_n; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("miso enabled outside frame");
  ////////////////////////////////////////////////////////////
  // Status updates
  property p_wel_rise; $rose(write_enable_latch) |-> cs_n; endproperty
  a_wel_rise: assert property (p_wel_rise)
    else $error("latch set inside frame");
  property p_apply; ($changed(protection_lock) || $changed(array_protect) || $changed(soft_reset_enable))
    |-> !write_enable_latch && cs_n; endproperty
  a_apply: assert property (p_apply)
    else $error("status change without latch clear");
  property p_lock_pin; $fell(protection_lock) |-> wp_n; endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock cleared with pin asserted");
  property p_prot_locked; $changed(array_protect) |-> !($past(protection_lock) && !wp_n); endproperty
  a_prot_locked: assert property (p_prot_locked)
    else $error("protect changed while locked");
  property p_rst_en_hold; $changed(soft_reset_enable) |-> $past(write_enable_latch); endproperty
  a_rst_en_hold: assert property (p_rst_en_hold)
    else $error("reset enable changed without latch");
  property p_accept; reset_cmd_accept == (reset_cmd_req && soft_reset_enable); endproperty
  a_accept: assert property (p_accept)
    else $error("reset accept wrong");
  property p_refuse; prog_erase_refused == (prog_erase_req && array_protect); endproperty
  a_refuse: assert property (p_refuse)
    else $error("program refusal wrong");
endmodule

// ### tb/spi_flash_status_write_logic_tb.sv
`timescale 1ns/1ns
module spi_flash_status_write_logic_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr, mo;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic busy_flag, program_error_flag, wp_n, reset_cmd_req, prog_erase_req;
  logic reset_cmd_accept, prog_erase_refused, soft_reset_enable, protection_lock, array_protect, write_enable_latch;
  logic [3:0] m;
  logic [7:0] ops [4] = '{8'h01, 8'h31, 8'h05, 8'h05};
  int nbs [8] = '{0, 3, 8, 8, 12, 16, 24, 31};
  int failures, n_compared, n_sck;
  sfsw_link_if link ();
  sfsw_flash_dev i_sfsw_flash_dev (.pclk, .presetn, .link(link), .busy_flag, .program_error_flag, .wp_n,
    .reset_cmd_req, .prog_erase_req, .reset_cmd_accept, .prog_erase_refused, .soft_reset_enable,
    .protection_lock, .array_protect, .write_enable_latch);
  sfsw_host_ctrl #(.HALF_CYC(4)) i_sfsw_host_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  sfsw_props i_sfsw_props (.pclk, .presetn, .sck(link.sck), .cs_n(link.cs_n), .miso_oe(link.miso_oe),
    .wp_n, .reset_cmd_req, .reset_cmd_accept, .prog_erase_req, .prog_erase_refused, .soft_reset_enable,
    .protection_lock, .array_protect, .write_enable_latch);
  ////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  // Opcode bits and clock count seen on the wire
  always @(posedge link.sck)
  begin
    if (n_sck < 8)
      mo <= {mo[6:0], link.mosi};
    n_sck <= n_sck + 1;
  end
  ////////////////////////////////////////////////////////////
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Next {reset enable, lock, protect, latch}
  function logic [3:0] f_next(input logic [3:0] s, input logic [7:0] op, input logic [7:0] d, input int nb,
    input logic wp);
    logic [3:0] n;
    n = s;
    if (op == sfsw_pkg::OP_WRITE_ENABLE)
      n[0] = 1'h1;
    else if ((op == sfsw_pkg::OP_WRITE_STATUS1 || op == sfsw_pkg::OP_WRITE_STATUS2) && s[0])
    begin
      n[0] = 1'h0;
      if (nb >= 8 && nb % 8 == 0)
      begin
        if (op == sfsw_pkg::OP_WRITE_STATUS2)
          n[3] = d[4];
        else if (wp || !s[2] || d[7])
        begin
          n[2] = d[7];
          if (wp || !s[2])
            n[1] = d[2];
        end
      end
    end
    return n;
  endfunction
  // Both status bytes
  function logic [15:0] f_stat(input logic [3:0] s, input logic b, input logic pe, input logic wp);
    return {s[2], 1'h0, pe, wp, 1'h0, s[1], s[0], b, 3'h0, s[3], 3'h0, b};
  endfunction
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task drive(input logic wp);
    rnd = xs(rnd);
    @(posedge pclk);
    wp_n <= wp;
    busy_flag <= rnd[0];
    program_error_flag <= rnd[1];
    reset_cmd_req <= rnd[2];
    prog_erase_req <= rnd[3];
    repeat (4) @(posedge pclk);
  endtask
  // One frame, then poll until idle and check
  task step(input logic [7:0] op, input logic [7:0] d0, input logic [7:0] d1, input int nb);
    int k;
    logic [15:0] e;
    n_sck = 0;
    apb(1'h1, sfsw_pkg::OFS_CMD, {3'h0, 5'(nb), d1, d0, op});
    k = 0;
    rd = 32'h1;
    while (rd[0] !== 1'h0 && k < 400)
    begin
      apb(1'h0, sfsw_pkg::OFS_STAT, 32'h0);
      k++;
    end
    chk("poll_done", 16'h0, {15'h0, rd[0]});
    repeat (4) @(posedge pclk);
    m = f_next(m, op, d0, nb, wp_n);
    chk("opcode", {8'h0, op}, {8'h0, mo});
    chk("sck_count", 16'(nb + 8), 16'(n_sck));
    chk("status", {12'h0, m}, {12'h0, soft_reset_enable, protection_lock, array_protect, write_enable_latch});
    chk("gates", {14'h0, reset_cmd_req & m[3], prog_erase_req & m[1]},
      {14'h0, reset_cmd_accept, prog_erase_refused});
    if (op == sfsw_pkg::OP_READ_STATUS && (nb == 16 || nb == 31))
    begin
      e = f_stat(m, busy_flag, program_error_flag, wp_n);
      if (nb == 31)
        e = {e[0], e[15:1]};
      chk("read_status", e, rd[31:16]);
    end
  endtask
  task tally_and_finish;
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {busy_flag, program_error_flag, reset_cmd_req, prog_erase_req} = 4'h0;
    wp_n = 1'h1;
    {failures, n_compared, n_sck} = '0;
    mo = 8'h00;
    m = 4'h0;
    rnd = 32'h00016BFE;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    chk("reset", 16'h0, {12'h0, soft_reset_enable, protection_lock, array_protect, write_enable_latch});
    drive(1'h1);
    step(8'h01, 8'h84, 8'h00, 8);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h01, 8'h84, 8'h00, 16);
    drive(1'h0);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h01, 8'h00, 8'h00, 8);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h01, 8'h80, 8'h00, 8);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h01, 8'h00, 8'h00, 5);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h31, 8'h10, 8'hEF, 16);
    step(8'h06, 8'h00, 8'h00, 0);
    step(8'h31, 8'h00, 8'h00, 12);
    step(8'h05, 8'h00, 8'h00, 31);
    for (int i = 0; i < 40; i++)
    begin
      drive(rnd[4]);
      step(8'h06, 8'h00, 8'h00, 0);
      step(ops[rnd[6:5]], rnd[15:8], rnd[23:16], nbs[rnd[10:8]]);
    end
    // Power cycle restores defaults
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    m = 4'h0;
    step(8'h05, 8'h00, 8'h00, 16);
    // Command word reads back as last written
    apb(1'h0, sfsw_pkg::OFS_CMD, 32'h0);
    chk("cmd_count", 16'h1000, rd[31:16]);
    chk("cmd_opcode", {8'h00, sfsw_pkg::OP_READ_STATUS}, rd[15:0]);
    apb(1'h0, 8'h08, 32'h0);
    chk("unmapped", 16'h1, {15'h0, se});
    tally_and_finish;
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
endmodule
